/* File: core/hgb_map.svh */
// Purpose: Addresses, strap masks, request codes and reset values for the GPIO bridge port
// Assumes: Byte addresses of the 32-bit register window for pins 64..95
// Notes:   Definitions only
`ifndef HGB_MAP_SVH
`define HGB_MAP_SVH
// ==========================================================
// Register byte addresses
`define HGB_ADDR_OEN    32'hbf80_0908
`define HGB_ADDR_IEN    32'hbf80_0918
`define HGB_ADDR_OUT    32'hbf80_0928
`define HGB_ADDR_IN     32'hbf80_0938
`define HGB_ADDR_PUE    32'hbf80_0948
`define HGB_ADDR_PDE    32'hbf80_0958
`define HGB_REG_RESET   32'h0000_0000
// ==========================================================
// Vendor request encodings
`define HGB_TYPE_RD     8'hc0
`define HGB_TYPE_WR     8'h40
`define HGB_CODE_RD     8'h04
`define HGB_CODE_WR     8'h03
// ==========================================================
// Feature controller port numbers
`define HGB_PORT_4DS    4'h6
`define HGB_PORT_6DS    4'h8
// ==========================================================
// Pins given to the GPIO function per strap option and with no EEPROM (bit n = pin 64+n)
`define HGB_MASK_I2C    32'hf000_50c0
`define HGB_MASK_I2S    32'h3000_0040
`define HGB_MASK_UART   32'hf000_0000
`define HGB_MASK_FLEX   32'hfc0c_50c0
`define HGB_MASK_FIFTH  32'hf000_50c0
`define HGB_MASK_NOEEP  32'h0000_0030
`endif

/* File: core/hgb_pkg.sv */
// Purpose: Types for the GPIO bridge port
// Assumes: One-hot state codes
// Notes:   Constants live in hgb_map.svh
package hgb_pkg;
  // ==========================================================
  // Request sequencer states
  typedef enum logic [3:0] {
    HGB_IDLE = 4'h1,
    HGB_WR   = 4'h2,
    HGB_RD   = 4'h4,
    HGB_ACK  = 4'h8
  } hgb_state_t;
  // Strap option codes
  typedef enum logic [2:0] {
    HGB_STRAP_I2C   = 3'h0,
    HGB_STRAP_I2S   = 3'h1,
    HGB_STRAP_UART  = 3'h2,
    HGB_STRAP_FLEX  = 3'h3,
    HGB_STRAP_FIFTH = 3'h4
  } hgb_strap_t;
endpackage

/* File: core/hgb_gpio_port.sv */
// Purpose: GPIO port behind the hub feature controller, pins 64..95
// Assumes: Feature controller decodes endpoint-zero setup and hands bytes over here
// Notes:   Strap and EEPROM presence are caught once after reset release
`include "hgb_map.svh"

module hgb_gpio_port #(
  parameter bit SIX_PORT = 1'b0                // Six downstream ports when set
) (
  input  wire logic        clk,                // 250 MHz hub clock
  input  wire logic        rst_n,              // Async reset, active low
  input  wire logic [2:0]  strap_option,       // Configuration strap, pin level
  input  wire logic        spi_eeprom_present, // SPI EEPROM fitted, pin level
  output logic      [3:0]  feature_port,       // Hub port number of the controller
  input  wire logic        setup_valid,        // Setup packet pulse
  input  wire logic [7:0]  request_type,       // Setup request type
  input  wire logic [7:0]  request_code,       // Setup request code
  input  wire logic [31:0] request_addr,       // Start byte address
  input  wire logic [15:0] request_len,        // Byte count
  input  wire logic        data_in_valid,      // Write data byte present
  input  wire logic [7:0]  data_in,            // Write data byte
  output logic             data_out_valid,     // Read data byte present
  output logic      [7:0]  data_out,           // Read data byte
  input  wire logic        data_out_ready,     // Read byte taken
  output logic             status_ack,         // Transfer complete pulse
  output logic             status_stall,       // Request refused pulse
  input  wire logic [31:0] pin_in,             // Pad levels, asynchronous
  output logic      [31:0] pin_out,            // Pad drive level
  output logic      [31:0] pin_oe,             // Pad drive enable, high drives
  output logic      [31:0] pin_pu,             // Pull-up on
  output logic      [31:0] pin_pd,             // Pull-down on
  input  wire logic [31:0] alt_out,            // Alternate function drive level
  input  wire logic [31:0] alt_oe              // Alternate function drive enable
);
  // ==========================================================
  // Storage
  logic [31:0] oen, ien, outr, pue, pde, in_state; // GPIO registers
  logic [31:0] pin_meta, pin_sync;                 // Input synchroniser
  logic [2:0]  strap_meta, strap_sync;             // Strap synchroniser
  logic        eep_meta, eep_sync;                 // EEPROM presence synchroniser
  logic        cfg_done;                           // Strap captured
  logic [31:0] gpio_sel;                           // Pins owned by GPIO
  hgb_pkg::hgb_state_t state;                      // Sequencer state
  logic [31:0] addr;                               // Current byte address
  logic [15:0] left;                               // Bytes still to move
  logic        bad_req;                            // Unknown request

  // ==========================================================
  // Feature port number
  assign feature_port = SIX_PORT ? `HGB_PORT_6DS : `HGB_PORT_4DS;

  // ==========================================================
  // Synchronisers; first stage read only by second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta   <= 32'h0;
      pin_sync   <= 32'h0;
      strap_meta <= 3'h0;
      strap_sync <= 3'h0;
      eep_meta   <= 1'b0;
      eep_sync   <= 1'b0;
    end else begin
      pin_meta   <= pin_in;
      pin_sync   <= pin_meta;
      strap_meta <= strap_option;
      strap_sync <= strap_meta;
      eep_meta   <= spi_eeprom_present;
      eep_sync   <= eep_meta;
    end
  end

  // ==========================================================
  // Strap capture: waits for the synchroniser to fill, then freezes
  logic [1:0] cfg_wait; // Settling count after release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_wait <= 2'h0;
      cfg_done <= 1'b0;
      gpio_sel <= 32'h0;
    end else if (!cfg_done) begin
      cfg_wait <= cfg_wait + 2'h1;
      if (cfg_wait == 2'h3) begin
        cfg_done <= 1'b1;
        // Unknown strap codes leave every pin on its alternate function when the EEPROM is fitted; with no EEPROM the mask is HGB_MASK_NOEEP
        unique case (strap_sync)
          hgb_pkg::HGB_STRAP_I2C:   gpio_sel <= `HGB_MASK_I2C;
          hgb_pkg::HGB_STRAP_I2S:   gpio_sel <= `HGB_MASK_I2S;
          hgb_pkg::HGB_STRAP_UART:  gpio_sel <= `HGB_MASK_UART;
          hgb_pkg::HGB_STRAP_FLEX:  gpio_sel <= `HGB_MASK_FLEX;
          hgb_pkg::HGB_STRAP_FIFTH: gpio_sel <= `HGB_MASK_FIFTH;
          default:                  gpio_sel <= 32'h0;
        endcase
        if (!eep_sync) begin
          gpio_sel <= `HGB_MASK_NOEEP | 32'h0;
        end
      end
    end
  end

  // ==========================================================
  // Pad steering: alternate function pins see none of the GPIO bits
  assign pin_oe  = (gpio_sel & oen) | (~gpio_sel & alt_oe);
  assign pin_out = (gpio_sel & outr) | (~gpio_sel & alt_out);
  assign pin_pu  = gpio_sel & pue;
  assign pin_pd  = gpio_sel & pde;

  // Input state follows the pad only where input is enabled and the pin is owned by GPIO
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_state <= `HGB_REG_RESET;
    end else begin
      in_state <= pin_sync & ien & gpio_sel;
    end
  end

  // ==========================================================
  // Byte read mux; unmapped addresses read zero
  function automatic logic [7:0] rd_byte(input logic [31:0] a);
    logic [31:0] w;
    w = 32'h0;
    unique case ({a[31:2], 2'b00})
      `HGB_ADDR_OEN: w = oen;
      `HGB_ADDR_IEN: w = ien;
      `HGB_ADDR_OUT: w = outr;
      `HGB_ADDR_IN:  w = in_state;
      `HGB_ADDR_PUE: w = pue;
      `HGB_ADDR_PDE: w = pde;
      default:       w = 32'h0;
    endcase
    return w[{a[1:0], 3'b000} +: 8];
  endfunction

  // ==========================================================
  // Request sequencer
  assign bad_req = !((request_type == `HGB_TYPE_RD && request_code == `HGB_CODE_RD) ||
                     (request_type == `HGB_TYPE_WR && request_code == `HGB_CODE_WR));
  wire wr_beat = (state == hgb_pkg::HGB_WR) && data_in_valid;
  wire rd_beat = (state == hgb_pkg::HGB_RD) && data_out_ready;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state        <= hgb_pkg::HGB_IDLE;
      addr         <= 32'h0;
      left         <= 16'h0;
      data_out     <= 8'h0;
      status_ack   <= 1'b0;
      status_stall <= 1'b0;
    end else begin
      status_ack   <= 1'b0;
      status_stall <= 1'b0;
      unique case (state)
        hgb_pkg::HGB_IDLE: begin
          if (setup_valid) begin
            addr     <= request_addr;
            left     <= request_len;
            data_out <= rd_byte(request_addr);
            if (bad_req) begin
              status_stall <= 1'b1;
            end else if (request_len == 16'h0) begin
              state <= hgb_pkg::HGB_ACK;
            end else if (request_type == `HGB_TYPE_RD) begin
              state <= hgb_pkg::HGB_RD;
            end else begin
              state <= hgb_pkg::HGB_WR;
            end
          end
        end
        hgb_pkg::HGB_WR: begin
          if (data_in_valid) begin
            addr <= addr + 32'h1;
            left <= left - 16'h1;
            if (left == 16'h1) begin
              state <= hgb_pkg::HGB_ACK;
            end
          end
        end
        hgb_pkg::HGB_RD: begin
          if (data_out_ready) begin
            addr     <= addr + 32'h1;
            left     <= left - 16'h1;
            data_out <= rd_byte(addr + 32'h1);
            if (left == 16'h1) begin
              state <= hgb_pkg::HGB_ACK;
            end
          end
        end
        hgb_pkg::HGB_ACK: begin
          status_ack <= 1'b1;
          state      <= hgb_pkg::HGB_IDLE;
        end
      endcase
    end
  end
  assign data_out_valid = (state == hgb_pkg::HGB_RD);

  // ==========================================================
  // Register writes; input state register is read only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oen  <= `HGB_REG_RESET;
      ien  <= `HGB_REG_RESET;
      outr <= `HGB_REG_RESET;
      pue  <= `HGB_REG_RESET;
      pde  <= `HGB_REG_RESET;
    end else if (wr_beat) begin
      unique case ({addr[31:2], 2'b00})
        `HGB_ADDR_OEN: oen[{addr[1:0], 3'b000} +: 8]  <= data_in;
        `HGB_ADDR_IEN: ien[{addr[1:0], 3'b000} +: 8]  <= data_in;
        `HGB_ADDR_OUT: outr[{addr[1:0], 3'b000} +: 8] <= data_in;
        `HGB_ADDR_PUE: pue[{addr[1:0], 3'b000} +: 8]  <= data_in;
        `HGB_ADDR_PDE: pde[{addr[1:0], 3'b000} +: 8]  <= data_in;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Assertions
  property p_port;
    @(posedge clk) disable iff (!rst_n) feature_port == (SIX_PORT ? 4'h8 : 4'h6);
  endproperty
  a_port: assert property (p_port) else $error("feature port wrong");
  property p_alt;
    @(posedge clk) disable iff (!rst_n) !cfg_done |-> (pin_pu | pin_pd) == 32'h0;
  endproperty
  a_alt: assert property (p_alt) else $error("pull active before config");
  property p_iso;
    @(posedge clk) disable iff (!rst_n) ((pin_oe ^ alt_oe) & ~gpio_sel) == 32'h0;
  endproperty
  a_iso: assert property (p_iso) else $error("GPIO leaks onto alt pin");
  property p_wr;
    @(posedge clk) disable iff (!rst_n)
      wr_beat && {addr[31:2], 2'b00} == `HGB_ADDR_OUT && addr[1:0] == 2'h0
      |=> outr[7:0] == $past(data_in);
  endproperty
  a_wr: assert property (p_wr) else $error("output byte not stored");
  property p_wr_ack;
    @(posedge clk) disable iff (!rst_n) wr_beat && left == 16'h1 |-> ##2 status_ack;
  endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("no ack after last write");
  property p_rd_ack;
    @(posedge clk) disable iff (!rst_n) rd_beat && left == 16'h1 |-> ##2 status_ack;
  endproperty
  a_rd_ack: assert property (p_rd_ack) else $error("no ack after last read");
  property p_stall;
    @(posedge clk) disable iff (!rst_n)
      state == hgb_pkg::HGB_IDLE && setup_valid && bad_req |=> status_stall && !status_ack;
  endproperty
  a_stall: assert property (p_stall) else $error("bad request not stalled");
  property p_in;
    @(posedge clk) disable iff (!rst_n) (in_state & ~$past(ien)) == 32'h0;
  endproperty
  a_in: assert property (p_in) else $error("input read without enable");
  property p_drive;
    @(posedge clk) disable iff (!rst_n)
      ((pin_out ^ outr) & gpio_sel & oen) == 32'h0;
  endproperty
  a_drive: assert property (p_drive) else $error("driven level differs");
  c_rd: cover property (@(posedge clk) disable iff (!rst_n) rd_beat ##[1:4] status_ack);
  c_wr: cover property (@(posedge clk) disable iff (!rst_n) wr_beat ##[1:4] status_ack);
  c_st: cover property (@(posedge clk) disable iff (!rst_n) status_stall);
endmodule

/* File: test/hgb_host_model.sv */
// Purpose: Host-side model issuing vendor control requests to the GPIO port
// Assumes: Drives at the falling edge, design samples at the rising edge
// Notes:   Returns {ack, stall} seen at the end of each transfer
`include "hgb_map.svh"

// ==========================================================
// Host request driver
module hgb_host_model (
  input  wire logic        clk,            // Hub clock
  input  wire logic        data_out_valid, // Read byte offered
  input  wire logic        status_ack,     // Transfer done
  input  wire logic        status_stall,   // Request refused
  output logic             setup_valid,    // Setup pulse
  output logic      [7:0]  request_type,   // Request type
  output logic      [7:0]  request_code,   // Request code
  output logic      [31:0] request_addr,   // Start address
  output logic      [15:0] request_len,    // Byte count
  output logic             data_in_valid,  // Write byte present
  output logic      [7:0]  data_in,        // Write byte
  output logic             data_out_ready  // Read byte taken
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle levels from time zero
  initial begin
    setup_valid = 1'b0;
    request_type = 8'h00;
    request_code = 8'h00;
    request_addr = 32'h0;
    request_len = 16'h0;
    data_in_valid = 1'b0;
    data_in = 8'h00;
    data_out_ready = 1'b0;
  end
  // One whole transfer: setup, len bytes, then wait for the status pulse
  task automatic xfer(input logic [7:0] t, input logic [7:0] c, input logic [31:0] a,
                      input logic [31:0] d, input int len, output logic [1:0] res);
    int n;
    int w;
    n = 0;
    w = 0;
    @(negedge clk);
    setup_valid = 1'b1;
    request_type = t;
    request_code = c;
    request_addr = a;
    request_len = 16'(len);
    @(negedge clk);
    setup_valid = 1'b0;
    // Write data phase, one byte per cycle, lane order little endian
    if (t == `HGB_TYPE_WR && c == `HGB_CODE_WR) begin
      for (n = 0; n < len; n++) begin
        data_in_valid = 1'b1;
        data_in = d[8*n +: 8];
        @(negedge clk);
      end
      data_in_valid = 1'b0;
      data_in = ~data_in; // Released line does not keep the last byte
    end
    // Read data phase with random stalls, as a real host may do
    if (t == `HGB_TYPE_RD && c == `HGB_CODE_RD) begin
      while (n < len && w < 400) begin
        data_out_ready = 1'($urandom_range(0, 1));
        @(posedge clk);
        if (data_out_valid && data_out_ready) n++;
        w++;
        @(negedge clk);
      end
      data_out_ready = 1'b0;
    end
    // Bounded wait for the status phase
    w = 0;
    while (w < 20 && !(status_ack || status_stall)) begin
      @(negedge clk);
      w++;
    end
    res = {status_ack, status_stall};
  endtask
endmodule

/* File: test/tb_top.sv */
// Purpose: Self-checking bench for the GPIO bridge port
// Assumes: Four-port variant, host model drives the request side
// Notes:   Read bytes are checked against a queue of expected bytes
`include "hgb_map.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals
  logic        clk = 1'b0;             // 250 MHz
  logic        rst_n = 1'b0;           // Async reset
  logic [2:0]  strap_option = 3'h3;    // Strap code
  logic        spi_eeprom_present = 1'b1; // EEPROM fitted
  logic [3:0]  feature_port;           // Controller port
  logic        setup_valid;            // From host model
  logic [7:0]  request_type;           // From host model
  logic [7:0]  request_code;           // From host model
  logic [31:0] request_addr;           // From host model
  logic [15:0] request_len;            // From host model
  logic        data_in_valid;          // From host model
  logic [7:0]  data_in;                // From host model
  logic        data_out_valid;         // Read byte offered
  logic [7:0]  data_out;               // Read byte
  logic        data_out_ready;         // From host model
  logic        status_ack;             // Done pulse
  logic        status_stall;           // Refusal pulse
  logic [31:0] pin_in = 32'h0;         // Pad levels
  logic [31:0] pin_out, pin_oe, pin_pu, pin_pd; // Pad controls
  logic [31:0] alt_out = 32'h0;        // Alternate drive
  logic [31:0] alt_oe = 32'h0;         // Alternate enable
  int          failures = 0;           // Mismatches
  int          tests_run = 0;          // Comparisons
  logic [7:0]  exp_q[$];               // Expected read bytes
  logic [7:0]  exp_b;                  // Oldest expected byte
  logic [31:0] m, v[6], mk[7];         // Masks and register values
  logic [1:0]  res;                    // {ack, stall}

  // ==========================================================
  // Clock, design and host
  always #2 clk = ~clk;
  hgb_gpio_port #(.SIX_PORT(1'b0)) uut (.clk(clk), .rst_n(rst_n), .strap_option(strap_option),
    .spi_eeprom_present(spi_eeprom_present), .feature_port(feature_port),
    .setup_valid(setup_valid), .request_type(request_type), .request_code(request_code),
    .request_addr(request_addr), .request_len(request_len), .data_in_valid(data_in_valid),
    .data_in(data_in), .data_out_valid(data_out_valid), .data_out(data_out),
    .data_out_ready(data_out_ready), .status_ack(status_ack), .status_stall(status_stall),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pu(pin_pu), .pin_pd(pin_pd),
    .alt_out(alt_out), .alt_oe(alt_oe));
  hgb_host_model host (.clk(clk), .data_out_valid(data_out_valid), .status_ack(status_ack),
    .status_stall(status_stall), .setup_valid(setup_valid), .request_type(request_type),
    .request_code(request_code), .request_addr(request_addr), .request_len(request_len),
    .data_in_valid(data_in_valid), .data_in(data_in), .data_out_ready(data_out_ready));

  // Monitor: every byte the host takes is matched with the oldest note
  always @(posedge clk) begin
    if (data_out_valid && data_out_ready) begin
      exp_b = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx; // Empty queue fails
      `CHK(data_out, exp_b)
    end
  end

  // ==========================================================
  // Tasks
  task automatic give_verdict();
    if (failures == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Reset with a given strap; the design captures it again after each release
  task automatic do_reset(input logic [2:0] s, input logic e);
    @(negedge clk);
    rst_n = 1'b0;
    strap_option = s;
    spi_eeprom_present = e;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    host.xfer(`HGB_TYPE_WR, `HGB_CODE_WR, a, d, 4, res);
    `CHK(res, 2'b10)
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    for (int i = 0; i < 4; i++) exp_q.push_back(e[8*i +: 8]);
    host.xfer(`HGB_TYPE_RD, `HGB_CODE_RD, a, 32'h0, 4, res);
    `CHK(res, 2'b10)
  endtask

  // Watchdog: far above the few hundred cycles the tests need
  initial begin
    #200000;
    failures++;
    give_verdict();
  end

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(37150));
    alt_out = $urandom;
    alt_oe = $urandom;
    m = `HGB_MASK_FLEX;
    do_reset(3'h3, 1'b1);
    `CHK(feature_port, `HGB_PORT_4DS)
    // Strap not yet captured: every pin still on its alternate function
    `CHK(pin_oe, alt_oe)
    `CHK(pin_out, alt_out)
    `CHK(pin_pu | pin_pd, 32'h0)
    for (int i = 0; i < 6; i++) rd(`HGB_ADDR_OEN + 32'(16 * i), 32'h0);
    // Program every register; the write to the input state is dropped
    for (int i = 0; i < 6; i++) begin
      v[i] = $urandom;
      wr(`HGB_ADDR_OEN + 32'(16 * i), v[i]);
    end
    `CHK(pin_oe, (v[0] & m) | (alt_oe & ~m))
    `CHK(pin_out, (v[2] & m) | (alt_out & ~m))
    `CHK(pin_pu, v[4] & m)
    `CHK(pin_pd, v[5] & m)
    pin_in = $urandom;
    repeat (5) @(negedge clk);
    v[3] = pin_in & v[1] & m;
    for (int i = 0; i < 6; i++) rd(`HGB_ADDR_OEN + 32'(16 * i), v[i]);
    // Single byte into the top lane of the output state
    host.xfer(`HGB_TYPE_WR, `HGB_CODE_WR, `HGB_ADDR_OUT + 32'h3, 32'ha5, 1, res);
    `CHK(pin_out[31:24], (8'ha5 & m[31:24]) | (alt_out[31:24] & ~m[31:24]))
    // Refused requests, zero length, unmapped address
    host.xfer(8'h40, 8'h05, `HGB_ADDR_OEN, 32'h0, 0, res);
    `CHK(res, 2'b01)
    host.xfer(8'hc1, `HGB_CODE_RD, `HGB_ADDR_OEN, 32'h0, 0, res);
    `CHK(res, 2'b01)
    host.xfer(`HGB_TYPE_WR, `HGB_CODE_WR, `HGB_ADDR_OEN, 32'h0, 0, res);
    `CHK(res, 2'b10)
    rd(32'hbf80_0a00, 32'h0);
    // Pin ownership for each strap option and for a missing EEPROM
    mk = '{`HGB_MASK_I2C, `HGB_MASK_I2S, `HGB_MASK_UART, `HGB_MASK_FLEX,
           `HGB_MASK_FIFTH, 32'h0, `HGB_MASK_NOEEP};
    alt_oe = 32'h0;
    for (int k = 0; k < 7; k++) begin
      do_reset((k < 6) ? 3'(k) : 3'h3, k < 6);
      wr(`HGB_ADDR_OEN, 32'hffff_ffff);
      `CHK(pin_oe, mk[k])
    end
    give_verdict();
  end
endmodule
